//--- design/rrt_ctrl.sv
// Receive sensitivity gate, radio state control and transmit ramp registers
// Behaviour
// - Detect-disable bit set blocks start of any new frame reception.
// - Setting detect-disable leaves a frame already being received undisturbed.
// - Detect-disable blocks regardless of the threshold code.
// - Nonzero threshold code rejects frames whose signal strength does not exceed threshold.
// - Threshold equals base value plus three times code minus one.
// - Threshold code zero accepts every frame regardless of strength.
// - Pin rising edge or start command begins transmit from idle or auto-retry.
// - Trigger enters busy transmit; modulation starts 16 us later.
// - Amplifier buffer and amplifier switch on one after the other.
// - Buffer lead code 0..3 gives one clock cycle, 2, 4, 6 us; default 3.
// - Buffer lead time drives the external front-end transmit switch.
// - Amplifier lead code 0..3 gives 2, 4, 6, 8 us; default 0.
// - Power code selects sixteen steps; zero is maximum, default zero.
// - Receive-on command accepted from off or idle states.
// - While detect-disable stays set, stay receiving and detect no header.
module rrt_ctrl #(
  parameter int RSSI_W = 8,
  parameter logic [7:0] SIGNAL_BASE_VALUE = 8'h10
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register access
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Pin
  input wire logic i_sleep_transmit_pin,
  // Receiver baseband
  input wire logic i_sync_header_det,
  input wire logic [RSSI_W-1:0] i_rssi,
  input wire logic i_rx_frame_end,
  output logic o_demod_start,
  output logic o_demod_abort,
  // Transmitter
  input wire logic i_tx_frame_end,
  output logic o_amp_buffer_en,
  output logic o_amp_en,
  output logic o_modulation_start,
  output logic o_rf_frontend_tx,
  output logic [3:0] o_output_power_code,
  output logic [2:0] o_radio_state
);
  logic [7:0] tx_power_reg;
  logic [7:0] rx_sens_reg;
  logic pin_sync1_reg;
  logic pin_sync2_reg;
  logic pin_prev_reg;
  logic pin_rise;
  logic cmd_wr;
  logic [4:0] cmd;
  logic tx_trigger;
  logic detect_disable;
  logic [3:0] sensitivity_threshold_code;
  logic [RSSI_W+6:0] receive_threshold;
  logic rssi_pass;
  rrt_pkg::rrt_state_t state_reg;
  rrt_pkg::rrt_state_t state_next;
  rrt_pkg::rrt_state_t tx_return_reg;
  rrt_pkg::rrt_state_t rx_return_reg;
  rrt_ramp_if rif ();

  // Register fields
  assign detect_disable = rx_sens_reg[rrt_pkg::DET_DIS_BIT];
  assign sensitivity_threshold_code = rx_sens_reg[rrt_pkg::THR_LSB +: 4];
  assign cmd_wr = i_reg_wr && (i_reg_addr == rrt_pkg::ADDR_STATE);
  assign cmd = i_reg_wdata[4:0];

  // Register writes
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_power_reg <= rrt_pkg::OUTPUT_POWER_CODE_RST;
      rx_sens_reg <= rrt_pkg::RX_SENS_RST;
    end else if (i_reg_wr) begin
      if (i_reg_addr == rrt_pkg::ADDR_OUTPUT_POWER_CODE) begin
        tx_power_reg <= i_reg_wdata;
      end
      if (i_reg_addr == rrt_pkg::ADDR_RX_SENS) begin
        rx_sens_reg <= i_reg_wdata & rrt_pkg::RX_SENS_WMASK;
      end
    end
  end

  // Register reads, one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        rrt_pkg::ADDR_STATE: o_reg_rdata <= {5'h00, state_reg};
        rrt_pkg::ADDR_OUTPUT_POWER_CODE: o_reg_rdata <= tx_power_reg;
        rrt_pkg::ADDR_RX_SENS: o_reg_rdata <= rx_sens_reg;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // Pin synchroniser and rising edge
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_sync1_reg <= 1'b0;
      pin_sync2_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_sync1_reg <= i_sleep_transmit_pin;
      pin_sync2_reg <= pin_sync1_reg;
      pin_prev_reg <= pin_sync2_reg;
    end
  end
  assign pin_rise = pin_sync2_reg && !pin_prev_reg;

  // Signal strength gate
  always_comb begin
    receive_threshold = (RSSI_W+7)'(SIGNAL_BASE_VALUE)
      + (RSSI_W+7)'(rrt_pkg::THR_STEP) * (RSSI_W+7)'(sensitivity_threshold_code - 4'h1);
    rssi_pass = (sensitivity_threshold_code == 4'h0)
      || ((RSSI_W+7)'(i_rssi) > receive_threshold);
  end

  // Transmit trigger from idle or auto-retry
  assign tx_trigger = ((state_reg == rrt_pkg::ST_PLL_ON) || (state_reg == rrt_pkg::ST_ARET_TX))
    && (pin_rise || (cmd_wr && cmd == rrt_pkg::CMD_TX_START));

  // Next radio state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rrt_pkg::ST_OFF, rrt_pkg::ST_PLL_ON: begin
        if (tx_trigger) begin
          state_next = rrt_pkg::ST_BUSY_TX;
        end else if (cmd_wr && cmd == rrt_pkg::CMD_RX_ON) begin
          state_next = rrt_pkg::ST_RX_ON;
        end else if (cmd_wr && cmd == rrt_pkg::CMD_AACK_ON) begin
          state_next = rrt_pkg::ST_AACK_RX;
        end else if (cmd_wr && cmd == rrt_pkg::CMD_PLL_ON) begin
          state_next = rrt_pkg::ST_PLL_ON;
        end else if (cmd_wr && cmd == rrt_pkg::CMD_ARET_ON) begin
          state_next = rrt_pkg::ST_ARET_TX;
        end else if (cmd_wr && cmd == rrt_pkg::CMD_OFF) begin
          state_next = rrt_pkg::ST_OFF;
        end
      end
      rrt_pkg::ST_RX_ON, rrt_pkg::ST_AACK_RX: begin
        if (i_sync_header_det && !detect_disable && rssi_pass) begin
          state_next = rrt_pkg::ST_BUSY_RX;
        end else if (cmd_wr && cmd == rrt_pkg::CMD_PLL_ON) begin
          state_next = rrt_pkg::ST_PLL_ON;
        end else if (cmd_wr && cmd == rrt_pkg::CMD_OFF) begin
          state_next = rrt_pkg::ST_OFF;
        end
      end
      rrt_pkg::ST_BUSY_RX: begin
        if (i_rx_frame_end) begin
          state_next = rx_return_reg;
        end
      end
      rrt_pkg::ST_ARET_TX: begin
        if (tx_trigger) begin
          state_next = rrt_pkg::ST_BUSY_TX;
        end else if (cmd_wr && cmd == rrt_pkg::CMD_PLL_ON) begin
          state_next = rrt_pkg::ST_PLL_ON;
        end
      end
      rrt_pkg::ST_BUSY_TX: begin
        if (i_tx_frame_end) begin
          state_next = tx_return_reg;
        end
      end
      default: state_next = rrt_pkg::ST_OFF;
    endcase
  end

  // Radio state and return states
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= rrt_pkg::ST_OFF;
      tx_return_reg <= rrt_pkg::ST_PLL_ON;
      rx_return_reg <= rrt_pkg::ST_RX_ON;
    end else begin
      state_reg <= state_next;
      if (tx_trigger) begin
        tx_return_reg <= state_reg;
      end
      if (state_next == rrt_pkg::ST_BUSY_RX && state_reg != rrt_pkg::ST_BUSY_RX) begin
        rx_return_reg <= state_reg;
      end
    end
  end

  // Demodulator start and abandon pulses
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_demod_start <= 1'b0;
      o_demod_abort <= 1'b0;
    end else begin
      o_demod_start <= (state_reg == rrt_pkg::ST_RX_ON || state_reg == rrt_pkg::ST_AACK_RX)
        && i_sync_header_det && !detect_disable && rssi_pass;
      o_demod_abort <= (state_reg == rrt_pkg::ST_RX_ON || state_reg == rrt_pkg::ST_AACK_RX)
        && i_sync_header_det && !detect_disable && !rssi_pass;
    end
  end

  // Ramp sequencer
  assign rif.start = tx_trigger;
  assign rif.buf_code = tx_power_reg[rrt_pkg::BUF_LT_LSB +: 2];
  assign rif.pa_code = tx_power_reg[rrt_pkg::AMP_LEAD_TIME_LSB +: 2];
  rrt_ramp_seq u_ramp (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .rif(rif)
  );

  // Transmit outputs
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_amp_buffer_en <= 1'b0;
      o_amp_en <= 1'b0;
      o_modulation_start <= 1'b0;
      o_rf_frontend_tx <= 1'b0;
      o_output_power_code <= rrt_pkg::OUTPUT_POWER_CODE_RST[rrt_pkg::PWR_LSB +: 4];
    end else begin
      o_amp_buffer_en <= rif.amp_buf_en && state_reg == rrt_pkg::ST_BUSY_TX;
      o_amp_en <= rif.amp_en && state_reg == rrt_pkg::ST_BUSY_TX;
      o_modulation_start <= rif.mod_start;
      o_rf_frontend_tx <= rif.amp_buf_en && state_reg == rrt_pkg::ST_BUSY_TX;
      o_output_power_code <= tx_power_reg[rrt_pkg::PWR_LSB +: 4];
    end
  end
  assign o_radio_state = state_reg;
endmodule

//--- design/rrt_pkg.sv
// Constants, encodings and timing for the receive gate and transmit ramp block
package rrt_pkg;
  // Register offsets
  localparam logic [5:0] ADDR_STATE = 6'h02;
  localparam logic [5:0] ADDR_OUTPUT_POWER_CODE = 6'h05;
  localparam logic [5:0] ADDR_RX_SENS = 6'h15;
  // Field positions
  localparam int DET_DIS_BIT = 7;
  localparam int THR_LSB = 0;
  localparam int BUF_LT_LSB = 6;
  localparam int AMP_LEAD_TIME_LSB = 4;
  localparam int PWR_LSB = 0;
  // Reset values
  localparam logic [7:0] OUTPUT_POWER_CODE_RST = 8'hc0;
  localparam logic [7:0] RX_SENS_RST = 8'h00;
  localparam logic [7:0] RX_SENS_WMASK = 8'h8f;
  // State command codes
  localparam logic [4:0] CMD_TX_START = 5'h01;
  localparam logic [4:0] CMD_OFF = 5'h02;
  localparam logic [4:0] CMD_RX_ON = 5'h03;
  localparam logic [4:0] CMD_PLL_ON = 5'h04;
  localparam logic [4:0] CMD_AACK_ON = 5'h05;
  localparam logic [4:0] CMD_ARET_ON = 5'h06;
  // Radio states
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_PLL_ON = 3'b001,
    ST_RX_ON = 3'b010,
    ST_AACK_RX = 3'b011,
    ST_BUSY_RX = 3'b100,
    ST_ARET_TX = 3'b101,
    ST_BUSY_TX = 3'b110
  } rrt_state_t;
  // Timing
  localparam int CLK_KHZ = 25000;
  localparam int MOD_START_US = 16;
  localparam int LEAD_STEP_US = 2;
  localparam int AMP_LEAD_TIME_MIN_US = 2;
  localparam int THR_STEP = 3;
  localparam int MOD_START_CYC = MOD_START_US * CLK_KHZ / 1000;
  localparam int STEP_CYC = LEAD_STEP_US * CLK_KHZ / 1000;
  localparam int AMP_LEAD_TIME_MIN_CYC = AMP_LEAD_TIME_MIN_US * CLK_KHZ / 1000;
  localparam int CNT_W = 10;
endpackage

//--- design/rrt_ramp_if.sv
// Signals between the controller and the transmit ramp sequencer
interface rrt_ramp_if;
  logic start;
  logic [1:0] buf_code;
  logic [1:0] pa_code;
  logic amp_buf_en;
  logic amp_en;
  logic mod_start;
  modport ctl (output start, buf_code, pa_code, input amp_buf_en, amp_en, mod_start);
  modport seq (input start, buf_code, pa_code, output amp_buf_en, amp_en, mod_start);
endinterface

//--- design/rrt_ramp_seq.sv
// Transmit start-up sequencer: amplifier buffer, amplifier, modulation start
module rrt_ramp_seq (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Controller side
  rrt_ramp_if.seq rif
);
  logic [rrt_pkg::CNT_W-1:0] cnt_reg;
  logic run_reg;
  logic [rrt_pkg::CNT_W-1:0] pa_on_at;
  logic [rrt_pkg::CNT_W-1:0] buf_on_at;

  // Lead code to cycles
  function automatic logic [rrt_pkg::CNT_W-1:0] lead_cyc(input logic [1:0] code);
    lead_cyc = rrt_pkg::CNT_W'(code) * rrt_pkg::CNT_W'(rrt_pkg::STEP_CYC);
  endfunction

  // Switch-on moments counted from the trigger
  always_comb begin
    pa_on_at = rrt_pkg::CNT_W'(rrt_pkg::MOD_START_CYC - rrt_pkg::AMP_LEAD_TIME_MIN_CYC)
      - lead_cyc(rif.pa_code);
    buf_on_at = pa_on_at - lead_cyc(rif.buf_code)
      - ((rif.buf_code == 2'b00) ? rrt_pkg::CNT_W'(1) : rrt_pkg::CNT_W'(0));
  end

  // Cycle counter from trigger to modulation start
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      run_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (rif.start) begin
      run_reg <= 1'b1;
      cnt_reg <= '0;
    end else if (run_reg) begin
      cnt_reg <= cnt_reg + rrt_pkg::CNT_W'(1);
      if (cnt_reg == rrt_pkg::CNT_W'(rrt_pkg::MOD_START_CYC - 1)) begin
        run_reg <= 1'b0;
      end
    end
  end

  // Buffer then amplifier, held until the next trigger ends the previous frame
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rif.amp_buf_en <= 1'b0;
      rif.amp_en <= 1'b0;
      rif.mod_start <= 1'b0;
    end else begin
      rif.mod_start <= run_reg && (cnt_reg == rrt_pkg::CNT_W'(rrt_pkg::MOD_START_CYC - 1));
      if (rif.start) begin
        rif.amp_buf_en <= 1'b0;
        rif.amp_en <= 1'b0;
      end else if (run_reg) begin
        if (cnt_reg == buf_on_at) begin
          rif.amp_buf_en <= 1'b1;
        end
        if (cnt_reg == pa_on_at) begin
          rif.amp_en <= 1'b1;
        end
      end
    end
  end
endmodule

//--- tb/rrt_monitor.sv
// Port checker for rrt_ctrl
module rrt_monitor #(
  parameter int RSSI_W = 8,
  parameter logic [7:0] SIGNAL_BASE_VALUE = 8'h10
) (
  // Inputs watched
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_reg_wr,
  input wire logic [5:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_sync_header_det,
  input wire logic [RSSI_W-1:0] i_rssi,
  input wire logic i_rx_frame_end,
  // Outputs watched
  input logic [2:0] o_radio_state,
  input logic o_demod_start,
  input logic o_demod_abort,
  input logic o_amp_buffer_en,
  input logic o_amp_en,
  input logic o_modulation_start,
  input logic o_rf_frontend_tx,
  input logic [3:0] o_output_power_code
);
  timeunit 1ns;
  timeprecision 1ps;
  // Trigger-to-modulation latency seen at the ports: counter span plus output register
  localparam int MOD_LAT = rrt_pkg::MOD_START_CYC + 1;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [7:0] sens_reg, pwr_reg, pwr_d;
  logic rx_st, take, pass;
  // Shadow copies of both registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sens_reg <= 8'h00;
      pwr_reg <= 8'hc0;
    end else if (i_reg_wr && i_reg_addr == rrt_pkg::ADDR_RX_SENS) begin
      sens_reg <= i_reg_wdata;
    end else if (i_reg_wr && i_reg_addr == rrt_pkg::ADDR_OUTPUT_POWER_CODE) begin
      pwr_reg <= i_reg_wdata;
    end
  end
  // One-cycle delayed power shadow
  always_ff @(posedge i_clk) begin
    pwr_d <= pwr_reg;
  end
  // Header acceptance decision
  assign rx_st = o_radio_state inside {rrt_pkg::ST_RX_ON, rrt_pkg::ST_AACK_RX};
  assign take = i_sync_header_det && rx_st && !sens_reg[7];
  assign pass = sens_reg[3:0] == 4'h0 || int'(i_rssi) > int'(SIGNAL_BASE_VALUE) + 3 * (int'(sens_reg[3:0]) - 1);
  sequence s_tx_go;
    $rose(o_radio_state == rrt_pkg::ST_BUSY_TX);
  endsequence
  a_hdr_accept: assert property (take && pass |=> o_demod_start && !o_demod_abort)
    else $error("frame not accepted");
  a_hdr_reject: assert property (take && !pass |=> o_demod_abort && !o_demod_start)
    else $error("frame not abandoned");
  a_det_block: assert property (i_sync_header_det && rx_st && sens_reg[7] |=> !o_demod_start && !o_demod_abort
    && o_radio_state == $past(o_radio_state)) else $error("blocked header acted on");
  a_busy_hold: assert property (o_radio_state == rrt_pkg::ST_BUSY_RX && !i_rx_frame_end && !i_reg_wr
    |=> o_radio_state == rrt_pkg::ST_BUSY_RX) else $error("reception disturbed");
  a_tx_enter: assert property (i_reg_wr && i_reg_addr == rrt_pkg::ADDR_STATE
    && i_reg_wdata[4:0] == rrt_pkg::CMD_TX_START && o_radio_state inside {rrt_pkg::ST_PLL_ON, rrt_pkg::ST_ARET_TX}
    |=> o_radio_state == rrt_pkg::ST_BUSY_TX) else $error("no busy transmit");
  a_mod_time: assert property (s_tx_go |-> ##[MOD_LAT:MOD_LAT] o_modulation_start)
    else $error("modulation start late");
  a_amp_order: assert property ($rose(o_amp_en) |-> $past(o_amp_buffer_en))
    else $error("amplifier before buffer");
  a_fe_follow: assert property (o_rf_frontend_tx == o_amp_buffer_en)
    else $error("front end mismatch");
  a_pwr_copy: assert property (pwr_reg == pwr_d |-> o_output_power_code == pwr_reg[3:0])
    else $error("power code mismatch");
  a_en_idle: assert property (o_radio_state != rrt_pkg::ST_BUSY_TX && $past(o_radio_state) != rrt_pkg::ST_BUSY_TX
    |-> !o_amp_en && !o_amp_buffer_en) else $error("enable outside transmit");
endmodule
bind rrt_ctrl rrt_monitor #(.RSSI_W(RSSI_W), .SIGNAL_BASE_VALUE(SIGNAL_BASE_VALUE)) u_mon (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_sync_header_det(i_sync_header_det), .i_rssi(i_rssi), .i_rx_frame_end(i_rx_frame_end),
  .o_radio_state(o_radio_state), .o_demod_start(o_demod_start), .o_demod_abort(o_demod_abort),
  .o_amp_buffer_en(o_amp_buffer_en), .o_amp_en(o_amp_en), .o_modulation_start(o_modulation_start),
  .o_rf_frontend_tx(o_rf_frontend_tx), .o_output_power_code(o_output_power_code));

//--- tb/rrt_host_model.sv
// Host register access model
module rrt_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [5:0] o_addr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 6'h00;
    o_wdata = 8'h00;
  end
  // Single write; lines scrambled once released
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // Single read, data taken after it settles
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk);
    #1 d = i_rdata;
  endtask
  // State command
  task automatic cmd(input logic [4:0] c);
    wr(rrt_pkg::ADDR_STATE, {3'h0, c});
  endtask
endmodule

//--- tb/rrt_ctrl_tb_top.sv
// Self-checking bench for rrt_ctrl
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module rrt_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] BASE = 8'h10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hdr = 1'b0;
  logic [7:0] rssi = 8'h00;
  logic rxe = 1'b0;
  logic txe = 1'b0;
  logic pin = 1'b0;
  logic wr, rd, ds, da, be, ae, ms, fe;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [3:0] pc;
  logic [2:0] st;
  int fail_count = 0;
  int total_checks = 0;
  rrt_host_model host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  rrt_ctrl #(.RSSI_W(8), .SIGNAL_BASE_VALUE(BASE)) dut (.i_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_sleep_transmit_pin(pin),
    .i_sync_header_det(hdr), .i_rssi(rssi), .i_rx_frame_end(rxe), .o_demod_start(ds), .o_demod_abort(da),
    .i_tx_frame_end(txe), .o_amp_buffer_en(be), .o_amp_en(ae), .o_modulation_start(ms),
    .o_rf_frontend_tx(fe), .o_output_power_code(pc), .o_radio_state(st));
  always #20 clk = ~clk;
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Header pulse and outcome
  task automatic rx_hdr(input logic [7:0] r, input logic eds, input logic eda);
    @(posedge clk);
    hdr <= 1'b1;
    rssi <= r;
    @(posedge clk);
    hdr <= 1'b0;
    #1;
    `CHK("demod_start", eds, ds)
    `CHK("demod_abort", eda, da)
  endtask
  task automatic end_rx;
    @(posedge clk);
    rxe <= 1'b1;
    @(posedge clk);
    rxe <= 1'b0;
    #1;
  endtask
  task automatic t_regs;
    host.rd(rrt_pkg::ADDR_OUTPUT_POWER_CODE, d);
    `CHK("output_power_code reset", 8'hc0, d)
    host.rd(rrt_pkg::ADDR_RX_SENS, d);
    `CHK("rx_sens reset", 8'h00, d)
    host.wr(rrt_pkg::ADDR_RX_SENS, 8'hff);
    host.rd(rrt_pkg::ADDR_RX_SENS, d);
    `CHK("reserved bits", 8'h8f, d)
    host.rd(6'h3f, d);
    `CHK("unmapped", 8'h00, d)
    host.wr(rrt_pkg::ADDR_RX_SENS, 8'h00);
    $display("t_regs done");
  endtask
  // Lead times, power code, both triggers
  task automatic t_tx;
    int t6, tb, ta, tm;
    host.cmd(rrt_pkg::CMD_PLL_ON);
    for (int b = 0; b < 4; b++) begin
      host.wr(rrt_pkg::ADDR_OUTPUT_POWER_CODE, {2'(b), 2'(b), 4'(b * 5)});
      if (b == 3) host.cmd(rrt_pkg::CMD_ARET_ON);
      // Register update then output register: two edges before the copy shows
      repeat (2) @(posedge clk);
      `CHK("power code", 4'(b * 5), pc)
      if (b[0]) pin <= 1'b1;
      else host.cmd(rrt_pkg::CMD_TX_START);
      t6 = -1;
      tb = -1;
      ta = -1;
      tm = -1;
      for (int k = 0; k < 600 && tm < 0; k++) begin
        @(posedge clk);
        #1;
        if (t6 < 0 && st === 3'h6) t6 = k;
        if (tb < 0 && be === 1'b1) tb = k;
        if (ta < 0 && ae === 1'b1) ta = k;
        if (ms === 1'b1) tm = k;
      end
      if (tm < 0) begin
        fail_count++;
        final_report;
      end
      `CHK("mod start", 1'b1, (tm - t6 - rrt_pkg::MOD_START_CYC) inside {-1, 0, 1})
      `CHK("buffer lead", (b == 0) ? 1 : 50 * b, ta - tb)
      `CHK("amp lead", 1'b1, (tm - ta - 50 * (b + 1)) inside {-1, 0, 1})
      `CHK("front end", 1'b1, fe)
      @(posedge clk);
      txe <= 1'b1;
      pin <= 1'b0;
      @(posedge clk);
      txe <= 1'b0;
      @(posedge clk);
      #1;
      `CHK("enables off", 2'b00, {be, ae})
    end
    host.cmd(rrt_pkg::CMD_PLL_ON);
    $display("t_tx done");
  endtask
  // Threshold codes 0, 1 and 15
  task automatic t_rx;
    logic [3:0] c;
    logic [7:0] t;
    host.cmd(rrt_pkg::CMD_RX_ON);
    #1;
    `CHK("rx on", 3'h2, st)
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 4'h0 : (i == 1) ? 4'h1 : 4'hf;
      t = BASE + 8'(3 * (int'(c) - 1));
      host.wr(rrt_pkg::ADDR_RX_SENS, {4'h0, c});
      if (c != 4'h0) rx_hdr(t, 1'b0, 1'b1);
      rx_hdr((c == 4'h0) ? 8'h00 : t + 8'h01, 1'b1, 1'b0);
      `CHK("busy rx", 3'h4, st)
      end_rx;
      `CHK("rx back", 3'h2, st)
    end
    $display("t_rx done");
  endtask
  // Detection disable before and during a frame
  task automatic t_dis;
    host.wr(rrt_pkg::ADDR_RX_SENS, 8'h8f);
    rx_hdr(8'hff, 1'b0, 1'b0);
    `CHK("stay rx", 3'h2, st)
    host.wr(rrt_pkg::ADDR_RX_SENS, 8'h00);
    rx_hdr(8'h00, 1'b1, 1'b0);
    host.wr(rrt_pkg::ADDR_RX_SENS, 8'h80);
    #1;
    `CHK("frame kept", 3'h4, st)
    end_rx;
    rx_hdr(8'hff, 1'b0, 1'b0);
    `CHK("still rx", 3'h2, st)
    $display("t_dis done");
  endtask
  // Auto-ack receive entered from off, state read back
  task automatic t_aack;
    host.wr(rrt_pkg::ADDR_RX_SENS, 8'h00);
    host.cmd(rrt_pkg::CMD_PLL_ON);
    host.cmd(rrt_pkg::CMD_OFF);
    host.rd(rrt_pkg::ADDR_STATE, d);
    `CHK("off state", 8'h00, d)
    host.cmd(rrt_pkg::CMD_AACK_ON);
    host.rd(rrt_pkg::ADDR_STATE, d);
    `CHK("aack state", 8'h03, d)
    rx_hdr(8'h00, 1'b1, 1'b0);
    `CHK("aack busy", 3'h4, st)
    end_rx;
    `CHK("aack back", 3'h3, st)
    $display("t_aack done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_tx;
    t_rx;
    t_dis;
    t_aack;
    final_report;
  end
  initial begin
    #3ms;
    fail_count++;
    final_report;
  end
endmodule
